/* File: rtl/xse_pkg.sv */
package xse_pkg;

  // -------------------------------------------------------------------------
  // Register layout
  // -------------------------------------------------------------------------
  localparam int          XSE_MASK_W        = 64;
  localparam int          XSE_FP_STACK_BIT  = 0;
  localparam int          XSE_VECTOR_BIT    = 1;
  localparam int          XSE_FIRST_EXT_BIT = 2;
  localparam int          XSE_RESERVED_BIT  = 63;
  localparam logic [63:0] XSE_MASK_RESET    = 64'h0000_0000_0000_0001;

  // -------------------------------------------------------------------------
  // Control register four and identification bit positions
  // -------------------------------------------------------------------------
  localparam int          XSE_CR4_TSR_BIT   = 2;
  localparam int          XSE_CR4_PCE_BIT   = 8;
  localparam int          XSE_CR4_OSXS_BIT  = 18;
  localparam int          XSE_ID_EXTENDED_STATE_SAVE_BIT  = 26;
  localparam int          XSE_ID_OSXS_BIT   = 27;
  localparam logic [31:0] XSE_CR4_IMPL_DEF  = 32'h0000_07ff;
  localparam logic [3:0]  XSE_TPR_INDEX     = 4'h8;

  // -------------------------------------------------------------------------
  // Instruction classes
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    XSE_OP_NONE,
    XSE_OP_READ_XCR,
    XSE_OP_WRITE_XCR,
    XSE_OP_CR_MOVE,
    XSE_OP_DR_MOVE,
    XSE_OP_CACHE_WB,
    XSE_OP_CACHE_DISCARD,
    XSE_OP_LEAVE_SMM,
    XSE_OP_READ_TSC,
    XSE_OP_READ_PMC,
    XSE_OP_ADJUST_RPL,
    XSE_OP_STATE_USE,
    XSE_OP_STATE_SAVE,
    XSE_OP_OTHER_PROT,
    XSE_OP_OTHER_OPEN
  } xse_op_e;

  typedef struct packed {
    logic        valid;
    xse_op_e     op;
    logic [1:0]  current_privilege_level;
    logic [3:0]  cr_index;
    logic [63:0] wdata;
    logic [63:0] state_mask;
    logic [63:0] save_mask;
  } xse_req_s;

  typedef struct packed {
    logic os_state_save_enable;
    logic timestamp_read_restrict;
    logic counter_read_enable;
    logic os_fx_save_support;
  } xse_cr4_s;

  typedef struct packed {
    logic        valid;
    logic        gp_fault;
    logic        ud_fault;
    logic [63:0] rdata;
    logic [63:0] save_select;
  } xse_resp_s;

endpackage : xse_pkg

/* File: rtl/xse_ext_state_gate.sv */
`timescale 1ns/10ps
module xse_ext_state_gate #(
  parameter logic        HAS_EXTENDED_STATE_SAVE     = 1'b1,
  parameter logic        HAS_LONG_ARCH = 1'b1,
  parameter logic [31:0] CR4_IMPL      = xse_pkg::XSE_CR4_IMPL_DEF
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire xse_pkg::xse_req_s req,
  input  wire xse_pkg::xse_cr4_s cr4,
  input  wire logic             long_mode,
  input  wire logic [63:0]      supported_mask,
  output xse_pkg::xse_resp_s    resp,
  output logic [63:0]           state_enable,
  output logic [31:0]           id_ecx,
  output logic [31:0]           id_cr4_impl
);
  import xse_pkg::*;

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  logic [63:0] extended_state_enable_mask_r;
  logic [63:0] extended_state_enable_mask_nxt;
  xse_resp_s   resp_r;
  xse_resp_s   resp_nxt;
  logic [31:0] id_ecx_r;
  logic [31:0] id_cr4_impl_r;
  logic [63:0] legal_mask;
  logic        priv_zero;
  logic        write_ok;

  assign priv_zero = (req.current_privilege_level == 2'h0);

  // Bit zero is always legal and the top bit never is, whatever the enumeration says.
  always_comb begin
    legal_mask                   = supported_mask;
    legal_mask[XSE_FP_STACK_BIT] = 1'b1;
    legal_mask[XSE_RESERVED_BIT] = 1'b0;
  end

  // -------------------------------------------------------------------------
  // Fault and answer selection
  // -------------------------------------------------------------------------
  always_comb begin
    resp_nxt       = '0;
    resp_nxt.valid = req.valid;
    write_ok       = 1'b0;
    if (req.valid) begin
      unique case (req.op)
        XSE_OP_READ_XCR: begin
          if (!HAS_EXTENDED_STATE_SAVE || !cr4.os_state_save_enable) begin
            resp_nxt.ud_fault = 1'b1;
          end else begin
            resp_nxt.rdata = extended_state_enable_mask_r;
          end
        end
        XSE_OP_WRITE_XCR: begin
          if (!HAS_EXTENDED_STATE_SAVE || !cr4.os_state_save_enable) begin
            resp_nxt.ud_fault = 1'b1;
          end else if (!priv_zero) begin
            resp_nxt.gp_fault = 1'b1;
          end else if (!req.wdata[XSE_FP_STACK_BIT]) begin
            resp_nxt.gp_fault = 1'b1;
          end else if ((req.wdata & ~legal_mask) != 64'h0) begin
            resp_nxt.gp_fault = 1'b1;
          end else begin
            write_ok = 1'b1;
          end
        end
        XSE_OP_CR_MOVE: begin
          if (!HAS_LONG_ARCH && req.cr_index == XSE_TPR_INDEX) begin
            resp_nxt.ud_fault = 1'b1;
          end else begin
            resp_nxt.gp_fault = !priv_zero;
          end
        end
        XSE_OP_DR_MOVE: begin
          resp_nxt.gp_fault = !priv_zero;
        end
        XSE_OP_CACHE_WB,
        XSE_OP_CACHE_DISCARD: begin
          resp_nxt.gp_fault = !priv_zero;
        end
        XSE_OP_LEAVE_SMM: begin
          resp_nxt.gp_fault = !priv_zero;
        end
        XSE_OP_OTHER_PROT: begin
          resp_nxt.gp_fault = !priv_zero;
        end
        XSE_OP_READ_TSC: begin
          resp_nxt.gp_fault = cr4.timestamp_read_restrict && !priv_zero;
        end
        XSE_OP_READ_PMC: begin
          resp_nxt.gp_fault = !cr4.counter_read_enable && !priv_zero;
        end
        XSE_OP_ADJUST_RPL: begin
          resp_nxt.ud_fault = long_mode;
        end
        XSE_OP_STATE_USE: begin
          // Only the upper components consult the enable mask; bit one never does.
          if ((req.state_mask[63:XSE_FIRST_EXT_BIT] & legal_mask[63:XSE_FIRST_EXT_BIT]
               & ~extended_state_enable_mask_r[63:XSE_FIRST_EXT_BIT]) != 62'h0) begin
            resp_nxt.ud_fault = 1'b1;
          end else if (req.state_mask[XSE_VECTOR_BIT] && !cr4.os_fx_save_support) begin
            resp_nxt.ud_fault = 1'b1;
          end
        end
        XSE_OP_STATE_SAVE: begin
          if (!HAS_EXTENDED_STATE_SAVE || !cr4.os_state_save_enable) begin
            resp_nxt.ud_fault = 1'b1;
          end else begin
            resp_nxt.save_select = extended_state_enable_mask_r & req.save_mask;
          end
        end
        XSE_OP_NONE,
        XSE_OP_OTHER_OPEN: begin
          resp_nxt.gp_fault = 1'b0;
        end
        default: begin
          resp_nxt.ud_fault = 1'b1;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Enable mask register
  // -------------------------------------------------------------------------
  always_comb begin
    extended_state_enable_mask_nxt = extended_state_enable_mask_r;
    if (write_ok) begin
      extended_state_enable_mask_nxt = req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      extended_state_enable_mask_r <= XSE_MASK_RESET;
    end else begin
      extended_state_enable_mask_r <= extended_state_enable_mask_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_r <= '0;
    end else begin
      resp_r <= resp_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // Identification bits
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      id_ecx_r      <= 32'h0;
      id_cr4_impl_r <= 32'h0;
    end else begin
      id_ecx_r                   <= 32'h0;
      id_ecx_r[XSE_ID_EXTENDED_STATE_SAVE_BIT] <= HAS_EXTENDED_STATE_SAVE;
      id_ecx_r[XSE_ID_OSXS_BIT]  <= HAS_EXTENDED_STATE_SAVE && cr4.os_state_save_enable;
      id_cr4_impl_r              <= CR4_IMPL & ~(32'h1 << XSE_CR4_PCE_BIT);
    end
  end

  assign resp         = resp_r;
  assign state_enable = extended_state_enable_mask_r;
  assign id_ecx       = id_ecx_r;
  assign id_cr4_impl  = id_cr4_impl_r;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence xcr_write_allowed_s;
    req.valid && req.op == XSE_OP_WRITE_XCR && HAS_EXTENDED_STATE_SAVE && cr4.os_state_save_enable
      && priv_zero;
  endsequence

  sequence bad_write_s;
    xcr_write_allowed_s ##0 (!req.wdata[0] || (req.wdata & ~legal_mask) != 64'h0);
  endsequence

  sequence good_write_s;
    xcr_write_allowed_s ##0 (req.wdata[0] && (req.wdata & ~legal_mask) == 64'h0);
  endsequence

  sequence state_use_s;
    req.valid && req.op == XSE_OP_STATE_USE;
  endsequence

  fp_bit_set_a: assert property (extended_state_enable_mask_r[0])
    else $error("fp stack enable bit is clear");
  top_bit_clear_a: assert property (!extended_state_enable_mask_r[63])
    else $error("reserved top enable bit is set");
  bad_write_kept_a: assert property (bad_write_s |=> resp_r.gp_fault
      && extended_state_enable_mask_r == $past(extended_state_enable_mask_r))
    else $error("faulting write changed mask or missed fault");
  good_write_a: assert property (good_write_s |=> !resp_r.gp_fault
      && extended_state_enable_mask_r == $past(req.wdata))
    else $error("accepted write not applied");
  access_gate_a: assert property (req.valid && req.op == XSE_OP_READ_XCR
      && !cr4.os_state_save_enable |=> resp_r.ud_fault)
    else $error("mask read without state-save enable not refused");
  write_priv_a: assert property (req.valid && req.op == XSE_OP_WRITE_XCR && HAS_EXTENDED_STATE_SAVE
      && cr4.os_state_save_enable && !priv_zero |=> resp_r.gp_fault
      && $stable(extended_state_enable_mask_r))
    else $error("unprivileged mask write not refused");
  prot_move_a: assert property (req.valid && !priv_zero
      && (req.op == XSE_OP_DR_MOVE || req.op == XSE_OP_LEAVE_SMM
      || req.op == XSE_OP_CACHE_WB || req.op == XSE_OP_CACHE_DISCARD) |=> resp_r.gp_fault)
    else $error("protected instruction allowed above level zero");
  tsc_gate_a: assert property (req.valid && req.op == XSE_OP_READ_TSC
      |=> resp_r.gp_fault == ($past(cr4.timestamp_read_restrict) && $past(req.current_privilege_level) != 2'h0))
    else $error("timestamp read gate wrong");
  pmc_gate_a: assert property (req.valid && req.op == XSE_OP_READ_PMC
      |=> resp_r.gp_fault == (!$past(cr4.counter_read_enable) && $past(req.current_privilege_level) != 2'h0))
    else $error("counter read gate wrong");
  rpl_long_a: assert property (req.valid && req.op == XSE_OP_ADJUST_RPL
      |=> resp_r.ud_fault == $past(long_mode))
    else $error("adjust privilege fault wrong in 64-bit mode");
  save_sel_a: assert property (req.valid && req.op == XSE_OP_STATE_SAVE && HAS_EXTENDED_STATE_SAVE
      && cr4.os_state_save_enable |=> resp_r.save_select
      == ($past(extended_state_enable_mask_r) & $past(req.save_mask)))
    else $error("save selection not mask and enable");
  mirror_a: assert property (!$past(rst)
      |-> id_ecx_r[XSE_ID_OSXS_BIT] == (HAS_EXTENDED_STATE_SAVE && $past(cr4.os_state_save_enable)))
    else $error("identification mirror bit wrong");
  reset_value_a: assert property ($past(rst)
      |-> extended_state_enable_mask_r == XSE_MASK_RESET)
    else $error("enable mask not at reset value after reset");
  id_feature_a: assert property (!$past(rst)
      |-> id_ecx_r[XSE_ID_EXTENDED_STATE_SAVE_BIT] == HAS_EXTENDED_STATE_SAVE)
    else $error("save feature identification bit wrong");
  cr4_report_a: assert property (!$past(rst) |-> !id_cr4_impl_r[XSE_CR4_PCE_BIT]
      && (id_cr4_impl_r | (32'h1 << XSE_CR4_PCE_BIT)) == (CR4_IMPL | (32'h1 << XSE_CR4_PCE_BIT)))
    else $error("control flag report wrong");
  upper_off_a: assert property (state_use_s ##0 ((req.state_mask & legal_mask
      & ~extended_state_enable_mask_r & ~64'h3) != 64'h0) |=> resp_r.ud_fault)
    else $error("disabled upper component not refused");
  low_state_a: assert property (state_use_s ##0
      (req.state_mask[63:XSE_FIRST_EXT_BIT] == 62'h0)
      |=> resp_r.ud_fault == ($past(req.state_mask[XSE_VECTOR_BIT])
      && !$past(cr4.os_fx_save_support)))
    else $error("low state fault not by vector support");
  cr_move_a: assert property (req.valid && req.op == XSE_OP_CR_MOVE
      && (HAS_LONG_ARCH || req.cr_index != XSE_TPR_INDEX)
      |=> !resp_r.ud_fault && resp_r.gp_fault == ($past(req.current_privilege_level) != 2'h0))
    else $error("control register move gate wrong");
  read_open_a: assert property (req.valid && req.op == XSE_OP_READ_XCR
      && HAS_EXTENDED_STATE_SAVE && cr4.os_state_save_enable |=> !resp_r.gp_fault && !resp_r.ud_fault
      && resp_r.rdata == $past(extended_state_enable_mask_r))
    else $error("mask read refused or wrong");
  open_instr_a: assert property (req.valid && req.op == XSE_OP_OTHER_OPEN
      |=> !resp_r.gp_fault && !resp_r.ud_fault)
    else $error("unprotected instruction refused");
  prot_other_a: assert property (req.valid && req.op == XSE_OP_OTHER_PROT
      && !priv_zero |=> resp_r.gp_fault)
    else $error("protected instruction allowed above level zero");
  write_gate_a: assert property (req.valid && req.op == XSE_OP_WRITE_XCR
      && !cr4.os_state_save_enable
      |=> resp_r.ud_fault && $stable(extended_state_enable_mask_r))
    else $error("mask write without state-save enable not refused");
  fp_clear_a: assert property (xcr_write_allowed_s ##0
      !req.wdata[XSE_FP_STACK_BIT] |=> resp_r.gp_fault)
    else $error("write clearing fp stack bit not refused");
  unsup_write_a: assert property (xcr_write_allowed_s ##0
      ((req.wdata & ~supported_mask & ~64'h1) != 64'h0 || req.wdata[XSE_RESERVED_BIT])
      |=> resp_r.gp_fault)
    else $error("write of unsupported bit not refused");
  resp_pulse_a: assert property (resp_r.valid == $past(req.valid))
    else $error("answer not one cycle after request");
  idle_quiet_a: assert property (!req.valid |=> resp_r == '0)
    else $error("answer fields set without request");

endmodule : xse_ext_state_gate

/* File: verif/xse_ext_state_gate_tb.sv */
`timescale 1ns/10ps
module xse_ext_state_gate_tb;
  import xse_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        clk;
  logic        rst;
  xse_req_s    req;
  xse_cr4_s    cr4;
  logic        long_mode;
  logic [63:0] supported_mask;
  xse_resp_s   resp;
  logic [63:0] state_enable;
  logic [31:0] id_ecx;
  logic [31:0] id_cr4_impl;
  logic [63:0] mask_m;
  logic [31:0] seed;
  int          n_errors;
  int          comparisons;
  int          cycles = 0;

  xse_ext_state_gate dut_u (
    .clk            (clk),
    .rst            (rst),
    .req            (req),
    .cr4            (cr4),
    .long_mode      (long_mode),
    .supported_mask (supported_mask),
    .resp           (resp),
    .state_enable   (state_enable),
    .id_ecx         (id_ecx),
    .id_cr4_impl    (id_cr4_impl)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // One instruction. The model waits for an edge first, so that levels changed by the
  // caller have settled before the faults are worked out.
  task automatic do_op(input xse_op_e op, input logic [1:0] current_privilege_level, input logic [63:0] wd);
    xse_req_s    r;
    logic [63:0] legal;
    logic [31:0] t;
    logic        gp;
    logic        ud;
    logic [63:0] rd;
    logic [63:0] sel;
    @(posedge clk);
    t = rnd();
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.current_privilege_level = current_privilege_level;
    r.cr_index = t[3:0];
    r.wdata = wd;
    r.state_mask = wd;
    r.save_mask = wd;
    legal = (supported_mask | 64'h1) & ~(64'h1 << 63);
    gp = 1'b0;
    ud = 1'b0;
    rd = '0;
    sel = '0;
    case (op)
      XSE_OP_READ_XCR: if (!cr4.os_state_save_enable) ud = 1'b1; else rd = mask_m;
      XSE_OP_WRITE_XCR: begin
        if (!cr4.os_state_save_enable) ud = 1'b1;
        else gp = current_privilege_level != 2'd0 || !wd[0] || (wd & ~legal) != 64'h0;
      end
      XSE_OP_STATE_SAVE: if (!cr4.os_state_save_enable) ud = 1'b1; else sel = mask_m & wd;
      XSE_OP_READ_TSC: gp = cr4.timestamp_read_restrict && current_privilege_level != 2'd0;
      XSE_OP_READ_PMC: gp = !cr4.counter_read_enable && current_privilege_level != 2'd0;
      XSE_OP_ADJUST_RPL: ud = long_mode;
      XSE_OP_STATE_USE: begin
        ud = (wd & legal & ~mask_m & ~64'h3) != 64'h0;
        ud = ud || (wd[1] && !cr4.os_fx_save_support);
      end
      XSE_OP_OTHER_OPEN: gp = 1'b0;
      default: gp = current_privilege_level != 2'd0;
    endcase
    if (op == XSE_OP_WRITE_XCR && !gp && !ud) mask_m = wd;
    req <= r;
    @(posedge clk);
    req <= '0;
    #1;
    check("resp_valid", 64'(resp.valid), 64'h1);
    check("gp_fault", 64'(resp.gp_fault), 64'(gp));
    check("ud_fault", 64'(resp.ud_fault), 64'(ud));
    check("rdata", resp.rdata, rd);
    check("save_select", resp.save_select, sel);
    check("state_enable", state_enable, mask_m);
    check("id_ecx", 64'(id_ecx), 64'((32'(cr4.os_state_save_enable) << XSE_ID_OSXS_BIT)
          | (32'h1 << XSE_ID_EXTENDED_STATE_SAVE_BIT)));
  endtask : do_op

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] t;
    logic [63:0] w;
    logic [3:0]  k;
    seed = 32'd78;
    n_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    req = '0;
    cr4 = '1;
    long_mode = 1'b1;
    supported_mask = 64'h7;
    mask_m = XSE_MASK_RESET;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset_mask", state_enable, XSE_MASK_RESET);
    check("idle_valid", 64'(resp.valid), 64'h0);
    check("id_extended_state_save", 64'(id_ecx[XSE_ID_EXTENDED_STATE_SAVE_BIT]), 64'h1);
    check("id_cr4", 64'(id_cr4_impl), 64'(XSE_CR4_IMPL_DEF & ~32'h100));
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h3);
    do_op(XSE_OP_READ_XCR, 2'd3, 64'h0);
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h2);
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h8000_0000_0000_0001);
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h9);
    do_op(XSE_OP_WRITE_XCR, 2'd1, 64'h1);
    do_op(XSE_OP_STATE_USE, 2'd3, 64'h4);
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h1);
    do_op(XSE_OP_STATE_USE, 2'd3, 64'h2);
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h7);
    do_op(XSE_OP_STATE_SAVE, 2'd3, 64'h5);
    do_op(XSE_OP_STATE_USE, 2'd3, 64'h4);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      cr4 <= p == 0 ? 4'hf : 4'h8;
      long_mode <= p == 0;
      for (int o = 1; o < 15; o++) begin
        do_op(xse_op_e'(o), 2'd0, 64'h3);
        do_op(xse_op_e'(o), 2'd3, 64'h3);
      end
    end
    @(posedge clk);
    cr4 <= 4'h7;
    do_op(XSE_OP_READ_XCR, 2'd0, 64'h0);
    do_op(XSE_OP_WRITE_XCR, 2'd0, 64'h1);
    for (int i = 0; i < 400; i++) begin
      t = rnd();
      if (t[3:0] == 4'h0) begin
        @(posedge clk);
        cr4 <= {t[4] | t[5], t[6], t[7], t[8]};
        long_mode <= t[9];
        supported_mask <= {32'h0, rnd()} & 64'hff;
      end
      w = {rnd(), rnd()};
      if (t[10]) w = (w & supported_mask & 64'h7fff_ffff_ffff_ffff) | 64'h1;
      k = 4'(t[31:28] % 4'd14) + 4'h1;
      do_op(xse_op_e'(k), t[12:11], w);
    end
    end_of_test();
  end
endmodule : xse_ext_state_gate_tb
